// ===== hw/xid_pkg.sv
// shared constants, types and helpers for the extended instruction decoder
// assumes one instruction clock and the core reset for every user
package xid_pkg;

    localparam int PTR_W  = 12;
    localparam int DATA_W = 8;
    localparam int PC_W   = 21;
    localparam int WORD_W = 16;

    // high byte of the extended literal opcodes
    localparam logic [7:0] OPC_ADD_PTR  = 8'hE8;
    localparam logic [7:0] OPC_SUB_PTR  = 8'hE9;
    localparam logic [7:0] OPC_PUSH_LIT = 8'hEA;
    localparam logic [7:0] OPC_MOVE_IDX = 8'hEB;

    localparam logic [15:0] WORD_CALL_W     = 16'h0014;
    localparam logic [3:0]  SECOND_WORD_NIB = 4'hF;

    // pointer field values
    localparam logic [1:0] SEL_PTR_TWO = 2'h2;
    localparam logic [1:0] SEL_RETURN  = 2'h3;

    // field positions
    localparam int ACCESS_BIT    = 8;
    localparam int MOVE_KIND_BIT = 7;
    localparam int SEL_LSB       = 6;

    localparam logic [7:0]        IDX_OFFSET_MAX = 8'h5F;
    localparam logic [PTR_W-1:0]  PTR_RESET      = 12'h000;
    localparam logic [PC_W-1:0]   PC_RESET       = 21'h00_0000;
    localparam logic [DATA_W-1:0] DATA_RESET     = 8'h00;

    typedef enum logic [1:0] {
        XID_PTR_HOLD,
        XID_PTR_ADD,
        XID_PTR_SUB,
        XID_PTR_LOAD
    } xid_ptr_op_e;

    typedef enum logic [1:0] {
        XID_RUN,
        XID_MOVE_WORD2,
        XID_RETURN_NOP
    } xid_state_e;

    // base plus unsigned offset, wrapping at the pointer width
    function automatic logic [PTR_W-1:0] xid_index(input logic [PTR_W-1:0] base, input logic [7:0] off);
        return base + {4'h0, off};
    endfunction

endpackage

// ===== hw/xid_ptr_file.sv
// three file select pointers with literal add, subtract and core load
// assumes at most one operation per cycle, chosen by the decoder
module xid_ptr_file (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // operation
    input  wire xid_pkg::xid_ptr_op_e      op,
    input  wire logic [1:0]                sel,
    input  wire logic [xid_pkg::PTR_W-1:0] operand,
    // pointer values
    output logic      [xid_pkg::PTR_W-1:0] ptr_zero,
    output logic      [xid_pkg::PTR_W-1:0] ptr_one,
    output logic      [xid_pkg::PTR_W-1:0] ptr_two
);

    typedef struct packed {
        logic [2:0][xid_pkg::PTR_W-1:0] ptr;
    } xid_ptr_s;

    xid_ptr_s q, d;

    always_comb begin
        d = q;
        // select value three names no pointer; any operation with it is ignored
        if (sel != 2'h3) begin
            case (op)
                xid_pkg::XID_PTR_ADD:  d.ptr[sel] = q.ptr[sel] + operand;
                xid_pkg::XID_PTR_SUB:  d.ptr[sel] = q.ptr[sel] - operand;
                xid_pkg::XID_PTR_LOAD: d.ptr[sel] = operand;
                default:               d.ptr[sel] = q.ptr[sel];
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= {3{xid_pkg::PTR_RESET}};
        end else begin
            q <= d;
        end
    end

    assign ptr_zero = q.ptr[0];
    assign ptr_one  = q.ptr[1];
    assign ptr_two  = q.ptr[2];

endmodule // xid_ptr_file

// ===== hw/xid_ext_decoder.sv
// decode and execute of the eight-opcode instruction extension
// assumes the core hands over one word per cycle on instr_valid, returns read data
// combinationally while mem_rd_en is high, and honours nop_cycle by flushing its fetch
//
// Contract
// - every extended feature stays inert unless extended_set_enable is high, except the second word of a move already begun.
// - with the extension enabled, standard byte and bit instructions may use indexed literal offset addressing.
// - add literal to pointer adds the 6-bit literal to the chosen pointer in one cycle, no flags.
// - the add form with pointer field three adds to pointer two and returns, two cycles, no flags.
// - the call through the working register word calls a target built from the working register, two cycles.
// - move indexed to file reads pointer two plus a 7-bit offset and writes a 12-bit file address, two words.
// - move indexed to indexed reads and writes at pointer two plus 7-bit offsets, two words, no flags.
// - push literal writes the 8-bit literal at pointer two and then decrements pointer two in one cycle.
// - subtract literal from pointer takes the 6-bit literal off the chosen pointer in one cycle, no flags.
// - the subtract form with pointer field three subtracts from pointer two and returns, two cycles.
// - the two pointer-two forms return on their own without a separate return word.
// - those forms load the program counter from the return stack top and run a no-operation second cycle.
// - enabled, access bit clear and file operand at most 95 selects indexed addressing off pointer two.
module xid_ext_decoder (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    // configuration
    input  wire logic                       extended_set_enable,
    // instruction stream
    input  wire logic                       instr_valid,
    input  wire logic [xid_pkg::WORD_W-1:0] instr_word,
    input  wire logic                       std_file_op,
    // core state
    input  wire logic [xid_pkg::DATA_W-1:0] working_register,
    input  wire logic [12:0]                pc_upper,
    input  wire logic [xid_pkg::PC_W-1:0]   pc_return,
    input  wire logic [xid_pkg::PC_W-1:0]   top_of_return_stack,
    input  wire logic [xid_pkg::DATA_W-1:0] mem_rd_data,
    // core pointer load
    input  wire logic                       ptr_wr_en,
    input  wire logic [1:0]                 ptr_wr_sel,
    input  wire logic [xid_pkg::PTR_W-1:0]  ptr_wr_data,
    // decode results
    output logic                            ext_taken,
    output logic                            std_pass,
    output logic                            idx_mode,
    output logic      [xid_pkg::PTR_W-1:0]  idx_addr,
    // data memory
    output logic                            mem_rd_en,
    output logic      [xid_pkg::PTR_W-1:0]  mem_rd_addr,
    output logic                            mem_wr_en,
    output logic      [xid_pkg::PTR_W-1:0]  mem_wr_addr,
    output logic      [xid_pkg::DATA_W-1:0] mem_wr_data,
    // program flow
    output logic                            pc_load,
    output logic      [xid_pkg::PC_W-1:0]   pc_target,
    output logic                            ret_push,
    output logic      [xid_pkg::PC_W-1:0]   ret_push_data,
    output logic                            ret_pop,
    output logic                            nop_cycle,
    // pointers
    output logic      [xid_pkg::PTR_W-1:0]  pointer_zero,
    output logic      [xid_pkg::PTR_W-1:0]  pointer_one,
    output logic      [xid_pkg::PTR_W-1:0]  pointer_two
);

    typedef struct packed {
        xid_pkg::xid_state_e          state;
        logic                         ext_taken;
        logic                         std_pass;
        logic                         idx_mode;
        logic [xid_pkg::PTR_W-1:0]    idx_addr;
        logic                         mem_rd_en;
        logic [xid_pkg::PTR_W-1:0]    mem_rd_addr;
        logic                         mem_wr_en;
        logic [xid_pkg::PTR_W-1:0]    mem_wr_addr;
        logic [xid_pkg::DATA_W-1:0]   mem_wr_data;
        logic                         pc_load;
        logic [xid_pkg::PC_W-1:0]     pc_target;
        logic                         ret_push;
        logic [xid_pkg::PC_W-1:0]     ret_push_data;
        logic                         ret_pop;
        logic                         nop_cycle;
        logic [xid_pkg::DATA_W-1:0]   held_data;
        logic                         move_kind;
    } xid_dec_s;

    xid_dec_s q, d;

    xid_pkg::xid_ptr_op_e           ptr_op;
    logic [1:0]                     ptr_sel;
    logic [xid_pkg::PTR_W-1:0]      ptr_operand;
    logic [xid_pkg::PTR_W-1:0]      ptr_two_now;

    // opcode fields
    logic [7:0]                     op_hi;
    logic [1:0]                     op_sel;
    logic [xid_pkg::PTR_W-1:0]      lit6;
    logic                           ext_en;
    logic [xid_pkg::DATA_W-1:0]     move_data;

    // word classes, read only while instr_valid
    logic                           is_arith;
    logic                           is_push;
    logic                           is_move;
    logic                           is_call;
    logic                           is_idx_std;

    // the add and subtract forms share one high-byte test
    function automatic logic is_ptr_arith(input logic [7:0] hi);
        return hi == xid_pkg::OPC_ADD_PTR || hi == xid_pkg::OPC_SUB_PTR;
    endfunction

    // access bit clear and a low file operand select indexed addressing
    function automatic logic low_access_operand(input logic [xid_pkg::WORD_W-1:0] w);
        return !w[xid_pkg::ACCESS_BIT] && w[7:0] <= xid_pkg::IDX_OFFSET_MAX;
    endfunction

    // the first move word, and the second of an indexed-to-indexed move, carry a 7-bit offset from pointer two in their low bits
    function automatic logic [xid_pkg::PTR_W-1:0] move_offset(input logic [xid_pkg::PTR_W-1:0]  base,
                                                              input logic [xid_pkg::WORD_W-1:0] w);
        return xid_pkg::xid_index(base, {1'b0, w[6:0]});
    endfunction

    // field slices of the word on offer
    assign op_hi  = instr_word[15:8];
    assign op_sel = instr_word[xid_pkg::SEL_LSB +: 2];
    assign lit6   = {6'h00, instr_word[5:0]};
    assign ext_en = extended_set_enable;

    assign is_arith   = is_ptr_arith(op_hi);
    assign is_push    = op_hi == xid_pkg::OPC_PUSH_LIT;
    assign is_move    = op_hi == xid_pkg::OPC_MOVE_IDX;
    assign is_call    = instr_word == xid_pkg::WORD_CALL_W;
    assign is_idx_std = std_file_op && low_access_operand(instr_word);

    // read data is only driven by the core while the read strobe is up
    assign move_data = q.mem_rd_en ? mem_rd_data : q.held_data;

    // one copy of the whole state; pulses default idle, held fields keep their value
    always_comb begin
        d             = q;
        d.ext_taken   = 1'b0;
        d.std_pass    = 1'b0;
        d.idx_mode    = 1'b0;
        d.mem_rd_en   = 1'b0;
        d.mem_wr_en   = 1'b0;
        d.pc_load     = 1'b0;
        d.ret_push    = 1'b0;
        d.ret_pop     = 1'b0;
        d.nop_cycle   = 1'b0;
        ptr_op        = xid_pkg::XID_PTR_HOLD;
        ptr_sel       = ptr_wr_sel;
        ptr_operand   = ptr_wr_data;
        // read data captured while it stands, for a second word that comes late
        if (q.mem_rd_en) begin
            d.held_data = mem_rd_data;
        end
        // core loads yield to extended pointer updates in the same cycle
        if (ptr_wr_en) begin
            ptr_op = xid_pkg::XID_PTR_LOAD;
        end
        case (q.state)
            xid_pkg::XID_RUN: begin
                if (instr_valid) begin
                    if (!ext_en) begin
                        d.std_pass = 1'b1;
                    end else if (is_arith) begin
                        d.ext_taken = 1'b1;
                        if (op_hi == xid_pkg::OPC_ADD_PTR) begin
                            ptr_op = xid_pkg::XID_PTR_ADD;
                        end else begin
                            ptr_op = xid_pkg::XID_PTR_SUB;
                        end
                        ptr_operand = lit6;
                        ptr_sel     = op_sel;
                        if (op_sel == xid_pkg::SEL_RETURN) begin
                            // pointer two update and the return pulses land at the same edge
                            ptr_sel     = xid_pkg::SEL_PTR_TWO;
                            d.pc_load   = 1'b1;
                            d.pc_target = top_of_return_stack;
                            d.ret_pop   = 1'b1;
                            d.nop_cycle = 1'b1;
                            d.state     = xid_pkg::XID_RETURN_NOP;
                        end
                    end else if (is_push) begin
                        // write goes to the old pointer while the decrement lands at the same edge
                        d.ext_taken   = 1'b1;
                        d.mem_wr_en   = 1'b1;
                        d.mem_wr_addr = ptr_two_now;
                        d.mem_wr_data = instr_word[7:0];
                        ptr_op        = xid_pkg::XID_PTR_SUB;
                        ptr_sel       = xid_pkg::SEL_PTR_TWO;
                        ptr_operand   = 12'h001;
                    end else if (is_move) begin
                        d.ext_taken   = 1'b1;
                        d.mem_rd_en   = 1'b1;
                        d.mem_rd_addr = move_offset(ptr_two_now, instr_word);
                        d.move_kind   = instr_word[xid_pkg::MOVE_KIND_BIT];
                        d.state       = xid_pkg::XID_MOVE_WORD2;
                    end else if (is_call) begin
                        // return address pushed and target loaded at one edge
                        d.ext_taken     = 1'b1;
                        d.pc_load       = 1'b1;
                        d.pc_target     = {pc_upper, working_register};
                        d.ret_push      = 1'b1;
                        d.ret_push_data = pc_return;
                        d.nop_cycle     = 1'b1;
                        d.state         = xid_pkg::XID_RETURN_NOP;
                    end else begin
                        // standard word: only its operand form is decided here
                        d.std_pass = 1'b1;
                        if (is_idx_std) begin
                            d.idx_mode = 1'b1;
                            d.idx_addr = xid_pkg::xid_index(ptr_two_now, instr_word[7:0]);
                        end
                    end
                end
            end
            xid_pkg::XID_MOVE_WORD2: begin
                // the move kind waits in its own flop, so idx_mode stays a clean pulse
                if (instr_valid) begin
                    d.ext_taken   = 1'b1;
                    d.mem_wr_en   = 1'b1;
                    d.mem_wr_data = move_data;
                    if (q.move_kind) begin
                        d.mem_wr_addr = move_offset(ptr_two_now, instr_word);
                    end else begin
                        d.mem_wr_addr = instr_word[11:0];
                    end
                    d.state = xid_pkg::XID_RUN;
                end
            end
            xid_pkg::XID_RETURN_NOP: begin
                // flushed word of the second cycle is dropped
                // a core pointer load in this cycle still lands
                d.state = xid_pkg::XID_RUN;
            end
            default: begin
                d.state = xid_pkg::XID_RUN;
            end
        endcase
    end

    // the copy is registered whole on every edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // constants only, so reset never depends on live inputs
            q.state         <= xid_pkg::XID_RUN;
            q.ext_taken     <= 1'b0;
            q.std_pass      <= 1'b0;
            q.idx_mode      <= 1'b0;
            q.idx_addr      <= xid_pkg::PTR_RESET;
            q.mem_rd_en     <= 1'b0;
            q.mem_rd_addr   <= xid_pkg::PTR_RESET;
            q.mem_wr_en     <= 1'b0;
            q.mem_wr_addr   <= xid_pkg::PTR_RESET;
            q.mem_wr_data   <= xid_pkg::DATA_RESET;
            q.pc_load       <= 1'b0;
            q.pc_target     <= xid_pkg::PC_RESET;
            q.ret_push      <= 1'b0;
            q.ret_push_data <= xid_pkg::PC_RESET;
            q.ret_pop       <= 1'b0;
            q.nop_cycle     <= 1'b0;
            q.held_data     <= xid_pkg::DATA_RESET;
            q.move_kind     <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // pointer updates land at the same edge as the decoded pulses
    xid_ptr_file u_ptr_file (
        .clock    (clock),
        .rst_n    (rst_n),
        .op       (ptr_op),
        .sel      (ptr_sel),
        .operand  (ptr_operand),
        .ptr_zero (pointer_zero),
        .ptr_one  (pointer_one),
        .ptr_two  (ptr_two_now)
    );

    // every output is a flop; pointer values come from the pointer file flops
    assign pointer_two   = ptr_two_now;
    assign ext_taken     = q.ext_taken;
    assign std_pass      = q.std_pass;
    assign idx_mode      = q.idx_mode;
    assign idx_addr      = q.idx_addr;
    assign mem_rd_en     = q.mem_rd_en;
    assign mem_rd_addr   = q.mem_rd_addr;
    assign mem_wr_en     = q.mem_wr_en;
    assign mem_wr_addr   = q.mem_wr_addr;
    assign mem_wr_data   = q.mem_wr_data;
    assign pc_load       = q.pc_load;
    assign pc_target     = q.pc_target;
    assign ret_push      = q.ret_push;
    assign ret_push_data = q.ret_push_data;
    assign ret_pop       = q.ret_pop;
    assign nop_cycle     = q.nop_cycle;

endmodule // xid_ext_decoder

// ===== tb/xid_ext_decoder_properties.sv
// concurrent checks on the ports of the extended instruction decoder, bound below
// assumes one clock and the asynchronous active-low core reset
module xid_ext_decoder_properties (
    // clock, reset, configuration
    input wire logic        clock, rst_n, extended_set_enable,
    // instruction stream and core state
    input wire logic        instr_valid, std_file_op,
    input wire logic [15:0] instr_word,
    input wire logic [7:0]  working_register, mem_rd_data,
    input wire logic [12:0] pc_upper,
    input wire logic [20:0] pc_return, top_of_return_stack, pc_target, ret_push_data,
    // decoder results
    input wire logic        ext_taken, std_pass, idx_mode, mem_rd_en, mem_wr_en,
    input wire logic        pc_load, ret_push, ret_pop, nop_cycle,
    input wire logic [11:0] idx_addr, mem_rd_addr, mem_wr_addr, pointer_zero, pointer_two,
    input wire logic [7:0]  mem_wr_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic go;
    logic move_wait;
    // a move whose second word did not follow its read pulse at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            move_wait <= 1'b0;
        end else begin
            move_wait <= (mem_rd_en || move_wait) && !instr_valid;
        end
    end
    // a word is taken while the extension is enabled, unless a flush cycle or a move's second word is pending
    assign go = instr_valid && extended_set_enable && !nop_cycle && !mem_rd_en && !move_wait;

    chk_off_inert: assert property (
        !extended_set_enable |=> !ext_taken && !idx_mode && !pc_load) else $error("extension acted while off");
    chk_off_std: assert property (
        instr_valid && !extended_set_enable |=> std_pass) else $error("word not passed on while off");
    chk_add_two: assert property (
        go && instr_word[15:6] == 10'h3A2 |=> ext_taken && !pc_load
        && pointer_two == $past(pointer_two) + $past(instr_word[5:0])) else $error("pointer add wrong");
    chk_sub_zero: assert property (
        go && instr_word[15:6] == 10'h3A4 |=> ext_taken
        && pointer_zero == $past(pointer_zero) - $past(instr_word[5:0])) else $error("pointer subtract wrong");
    chk_ret_form: assert property (
        go && instr_word[15:9] == 7'h74 && instr_word[7:6] == 2'h3 |=> pc_load && ret_pop && nop_cycle
        && pc_target == $past(top_of_return_stack)) else $error("auto return missing");
    chk_call_working_register: assert property (
        go && instr_word == xid_pkg::WORD_CALL_W |=> pc_load && ret_push && nop_cycle && !ret_pop
        && pc_target == {$past(pc_upper), $past(working_register)} && ret_push_data == $past(pc_return))
        else $error("call through working register wrong");
    chk_nop_quiet: assert property (
        nop_cycle |=> !ext_taken && !std_pass && !nop_cycle) else $error("word taken in flush cycle");
    chk_push_lit: assert property (
        go && instr_word[15:8] == xid_pkg::OPC_PUSH_LIT |=> ext_taken && mem_wr_en
        && mem_wr_addr == $past(pointer_two) && mem_wr_data == $past(instr_word[7:0])
        && pointer_two == $past(pointer_two) - 12'h001) else $error("push literal wrong");
    chk_move_read: assert property (
        go && instr_word[15:8] == xid_pkg::OPC_MOVE_IDX |=> ext_taken && mem_rd_en && !mem_wr_en
        && mem_rd_addr == $past(pointer_two) + $past(instr_word[6:0])) else $error("move source read wrong");
    chk_move_write: assert property (
        mem_rd_en && instr_valid |=> ext_taken && mem_wr_en && mem_wr_data == $past(mem_rd_data))
        else $error("move write wrong");
    chk_move_late: assert property (
        move_wait && instr_valid |=> ext_taken && mem_wr_en && !mem_rd_en) else $error("late move write missing");
    chk_idx_mode: assert property (
        go && std_file_op |=> std_pass && !ext_taken
        && idx_mode == (!$past(instr_word[8]) && $past(instr_word[7:0]) <= xid_pkg::IDX_OFFSET_MAX)
        && (!idx_mode || idx_addr == $past(pointer_two) + $past(instr_word[7:0]))) else $error("indexed mode wrong");

    cov_push: cover property (mem_wr_en && !mem_rd_en);
    cov_ret: cover property (ret_pop ##1 !ext_taken);
    cov_move: cover property (mem_rd_en ##1 mem_wr_en);
    cov_idx: cover property (idx_mode);
    cov_late: cover property (move_wait ##1 mem_wr_en);
endmodule // xid_ext_decoder_properties

bind xid_ext_decoder xid_ext_decoder_properties u_xid_ext_decoder_properties (.*);

// ===== tb/tb_top.sv
// self-checking bench for the extended instruction decoder
// assumes the bound checker beside it; bench plays the core side
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, rst_n, extended_set_enable, instr_valid, std_file_op, ptr_wr_en;
    logic [15:0] instr_word;
    logic [7:0]  working_register, mem_rd_data, mem_wr_data;
    logic [12:0] pc_upper;
    logic [20:0] pc_return, top_of_return_stack, pc_target, ret_push_data;
    logic [1:0]  ptr_wr_sel;
    logic [11:0] ptr_wr_data, idx_addr, mem_rd_addr, mem_wr_addr, pointer_zero, pointer_one, pointer_two;
    logic        ext_taken, std_pass, idx_mode, mem_rd_en, mem_wr_en, pc_load, ret_push, ret_pop, nop_cycle;
    int          err_total = 0;
    int          compares = 0;
    typedef struct packed {logic [15:0] w; logic so, ext, std, idx; logic [11:0] p0, p2;} xid_row_s;
    xid_row_s    rows [10] = '{
        '{16'hE8A3, 1'h0, 1'h1, 1'h0, 1'h0, 12'h000, 12'h422}, '{16'hE981, 1'h0, 1'h1, 1'h0, 1'h0, 12'h000, 12'h421},
        '{16'hEA55, 1'h0, 1'h1, 1'h0, 1'h0, 12'h000, 12'h420}, '{16'h0612, 1'h1, 1'h0, 1'h1, 1'h1, 12'h000, 12'h420},
        '{16'h065F, 1'h1, 1'h0, 1'h1, 1'h1, 12'h000, 12'h420}, '{16'h0660, 1'h1, 1'h0, 1'h1, 1'h0, 12'h000, 12'h420},
        '{16'h0712, 1'h1, 1'h0, 1'h1, 1'h0, 12'h000, 12'h420}, '{16'hE805, 1'h0, 1'h1, 1'h0, 1'h0, 12'h005, 12'h420},
        '{16'hE906, 1'h0, 1'h1, 1'h0, 1'h0, 12'hFFF, 12'h420}, '{16'hE83F, 1'h0, 1'h1, 1'h0, 1'h0, 12'h03E, 12'h420}};
    logic [15:0] off_words [3] = '{16'hE8A3, 16'h0014, 16'h0612};

    // core answers reads only while the strobe stands; the pattern catches stale data
    assign mem_rd_data = mem_rd_en ? mem_rd_addr[7:0] ^ 8'h3C : 8'hFF;

    xid_ext_decoder u_xid_ext_decoder (.*);

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic en);
        rst_n = 1'h0;
        extended_set_enable = en;
        instr_valid = 1'h0;
        repeat (12) @(posedge clock);
        #1;
        `CHK("reset ext_taken", 1'h0, ext_taken)
        `CHK("reset pointer_two", 12'h000, pointer_two)
        `CHK("reset nop_cycle", 1'h0, nop_cycle)
        rst_n = 1'h1;
    endtask

    task automatic load_two(input logic [11:0] v);
        instr_valid = 1'h0;
        ptr_wr_en = 1'h1;
        ptr_wr_data = v;
        @(posedge clock);
        #1 ptr_wr_en = 1'h0;
    endtask

    // holds the word valid; the next call or an idle overwrites it
    task automatic issue(input logic [15:0] w, input logic so);
        instr_valid = 1'h1;
        instr_word = w;
        std_file_op = so;
        @(posedge clock);
        #1;
    endtask

    initial begin
        rst_n = 1'h0;
        extended_set_enable = 1'h1;
        instr_valid = 1'h0;
        instr_word = 16'h0000;
        std_file_op = 1'h0;
        working_register = 8'h5A;
        pc_upper = 13'h0123;
        pc_return = 21'h0_0456;
        top_of_return_stack = 21'h1_2345;
        ptr_wr_en = 1'h0;
        ptr_wr_sel = 2'h2;
        ptr_wr_data = 12'h000;
        do_reset(1'h1);
        load_two(12'h3FF);
        foreach (rows[i]) begin
            issue(rows[i].w, rows[i].so);
            `CHK("ext_taken", rows[i].ext, ext_taken)
            `CHK("std_pass", rows[i].std, std_pass)
            `CHK("idx_mode", rows[i].idx, idx_mode)
            `CHK("pointer_zero", rows[i].p0, pointer_zero)
            `CHK("pointer_two", rows[i].p2, pointer_two)
        end
        `CHK("idx_addr", 12'h47F, idx_addr)
        load_two(12'h3FF);
        issue(16'hE8E3, 1'h0);
        `CHK("add ret pointer_two", 12'h422, pointer_two)
        `CHK("add ret pc_target", 21'h1_2345, pc_target)
        `CHK("add ret pop", 1'h1, ret_pop)
        `CHK("add ret nop", 1'h1, nop_cycle)
        issue(16'hEA77, 1'h0);
        `CHK("flush ext_taken", 1'h0, ext_taken)
        `CHK("flush pointer_two", 12'h422, pointer_two)
        issue(16'hE9C2, 1'h0);
        `CHK("sub ret pointer_two", 12'h420, pointer_two)
        `CHK("sub ret pc_load", 1'h1, pc_load)
        issue(16'h0014, 1'h0);
        `CHK("call in flush", 1'h0, ret_push)
        issue(16'h0014, 1'h0);
        `CHK("call pc_target", 21'h1_235A, pc_target)
        `CHK("call push data", 21'h0_0456, ret_push_data)
        issue(16'hEB05, 1'h0);
        issue(16'hEB05, 1'h0);
        `CHK("move rd_addr", 12'h425, mem_rd_addr)
        `CHK("move rd_en", 1'h1, mem_rd_en)
        issue(16'hF123, 1'h0);
        `CHK("move wr_addr", 12'h123, mem_wr_addr)
        `CHK("move wr_data", 8'h19, mem_wr_data)
        issue(16'hEB83, 1'h0);
        `CHK("moves rd_addr", 12'h423, mem_rd_addr)
        issue(16'hF005, 1'h0);
        `CHK("moves wr_addr", 12'h425, mem_wr_addr)
        `CHK("moves wr_data", 8'h1F, mem_wr_data)
        issue(16'hEA01, 1'h0);
        `CHK("push wr_addr", 12'h420, mem_wr_addr)
        `CHK("push pointer_two", 12'h41F, pointer_two)
        `CHK("push wr_en", 1'h1, mem_wr_en)
        issue(16'hE841, 1'h0);
        `CHK("add pointer_one", 12'h001, pointer_one)
        // a core load in the same cycle as an extended update is dropped
        ptr_wr_en = 1'h1;
        ptr_wr_data = 12'h000;
        issue(16'hE802, 1'h0);
        ptr_wr_en = 1'h0;
        `CHK("clash pointer_zero", 12'h040, pointer_zero)
        `CHK("clash pointer_two", 12'h41F, pointer_two)
        // select three names no pointer, so the load is ignored
        ptr_wr_sel = 2'h3;
        load_two(12'h777);
        ptr_wr_sel = 2'h2;
        `CHK("sel3 pointer_zero", 12'h040, pointer_zero)
        `CHK("sel3 pointer_one", 12'h001, pointer_one)
        `CHK("sel3 pointer_two", 12'h41F, pointer_two)
        // second move word a cycle late: data must come from the capture
        issue(16'hEB10, 1'h0);
        instr_valid = 1'h0;
        @(posedge clock);
        #1;
        `CHK("late gap wr_en", 1'h0, mem_wr_en)
        issue(16'hF0AB, 1'h0);
        `CHK("late wr_addr", 12'h0AB, mem_wr_addr)
        `CHK("late wr_data", 8'h13, mem_wr_data)
        do_reset(1'h0);
        foreach (off_words[i]) begin
            issue(off_words[i], 1'h1);
            `CHK("off std_pass", 1'h1, std_pass)
            `CHK("off ext_taken", 1'h0, ext_taken)
            `CHK("off idx_mode", 1'h0, idx_mode)
            `CHK("off pc_load", 1'h0, pc_load)
            `CHK("off pointer_two", 12'h000, pointer_two)
        end
        instr_valid = 1'h0;
        repeat (2) @(posedge clock);
        conclude();
    end

    // the whole run needs well under two hundred cycles
    initial begin
        repeat (2000) @(posedge clock);
        err_total++;
        conclude();
    end
endmodule // tb_top
